// >>> src/somcw_pkg.sv
// Purpose: Shared constants and types for the sensor output mux and control word block.
// Assumes: APB with 32-bit data; every register index sits at byte address four times the index.
// Notes:   Registers are eight bits wide and the bits above them read as zero.
package somcw_pkg;

  // Channel and word geometry.
  localparam int          NUM_CH      = 16;
  localparam int          WORD_W      = 12;
  localparam int          BURST_LEN   = 128;
  localparam logic [6:0]  BURST_LAST  = 7'h7f;
  localparam logic [3:0]  WIDTH_10    = 4'ha;
  localparam logic [3:0]  WIDTH_12    = 4'hc;
  localparam logic [2:0]  BIT_DIV_10  = 3'h4;      // 10 bits x 4 cycles fill one 160 ns pixel.
  localparam logic [2:0]  BIT_DIV_12  = 3'h3;      // 12 bits x 3 cycles fit inside one pixel.
  localparam logic [11:0] CTRL_FIXED  = 12'h200;   // Constant one in bit 9, idle value 512.

  // Register indices; the byte address is four times the index.
  localparam logic [9:0]  IDX_TRAIN_LO = 10'h04e;
  localparam logic [9:0]  IDX_TRAIN_HI = 10'h04f;
  localparam logic [9:0]  IDX_CHDIS_0  = 10'h050;
  localparam logic [9:0]  IDX_CHDIS_1  = 10'h051;
  localparam logic [9:0]  IDX_CHDIS_2  = 10'h052;
  localparam logic [9:0]  IDX_SEL_A    = 10'h06c;
  localparam logic [9:0]  IDX_SEL_B    = 10'h06d;
  localparam logic [9:0]  IDX_MODE     = 10'h070;
  localparam logic [9:0]  IDX_ROWS_LO  = 10'h071;
  localparam logic [9:0]  IDX_ROWS_HI  = 10'h072;
  localparam logic [9:0]  IDX_STATUS   = 10'h073;

  // Values after reset.
  localparam logic [11:0] TRAIN_RESET  = 12'h3a5;
  localparam logic [15:0] ROWS_RESET   = 16'h0440;  // 1088 rows.
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [7:0]  MODE_RESET   = 8'h00;

  // Status pin select encodings.
  localparam logic [7:0]  SEL_INTE_A   = 8'h00;
  localparam logic [7:0]  SEL_INTE_B   = 8'h01;
  localparam logic [7:0]  SEL_PIXVAL   = 8'h02;
  localparam logic [7:0]  SEL_LINEVAL  = 8'h03;
  localparam logic [7:0]  SEL_FRAMEVAL = 8'h04;

  // Output multiplex modes, the code being log2 of the group size.
  typedef enum logic [1:0] {
    MUX_16 = 2'h0,
    MUX_8  = 2'h1,
    MUX_4  = 2'h2,
    MUX_2  = 2'h3
  } somcw_mode_type;

  // Read-out sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_ROW_OH  = 4'b0010,
    ST_SLOT_OH = 4'b0100,
    ST_BURST   = 4'b1000
  } somcw_state_type;

  // Status flags in control word bit order [7:0].
  typedef struct packed {
    logic integration_block_b_flag;
    logic integration_block_a_flag;
    logic fot_flag;
    logic row_overhead_flag;
    logic slot_overhead_flag;
    logic frame_valid_flag;
    logic line_valid_flag;
    logic pixel_valid_flag;
  } somcw_flags_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } somcw_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } somcw_apb_rsp_type;

  typedef logic [NUM_CH-1:0][WORD_W-1:0] somcw_pix_type;

endpackage : somcw_pkg

// >>> src/somcw_output_stage.sv
// Purpose: Sensor output stage: burst sequencer, channel multiplex, control word and serialisers.
// Assumes: i_master_clk is the pixel clock pin, far slower than i_ref_clk; other inputs share i_ref_clk.
// Notes:   One pixel period is one master clock period; every serial lane reloads once per pixel.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module somcw_output_stage
  import somcw_pkg::*;
(
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_arst_n,
  input  wire somcw_pkg::somcw_apb_req_type i_apb,
  output      somcw_pkg::somcw_apb_rsp_type o_apb,
  input  wire logic                        i_master_clk,
  input  wire logic                        i_readout_start,
  input  wire logic                        i_fot_active,
  input  wire logic                        i_inte_a,
  input  wire logic                        i_inte_b,
  input  wire somcw_pkg::somcw_pix_type    i_pixel_data,
  output      logic                        o_pixel_take,
  output      logic [2:0]                  o_burst_index,
  output      logic [15:0]                 o_data_serial,
  output      logic [15:0]                 o_data_oe,
  output      logic                        o_ctrl_serial,
  output      logic                        o_serial_output_clock,
  output      logic                        o_status_pin_a,
  output      logic                        o_status_pin_b
);
  import somcw_pkg::*;

  // Register file.
  logic [11:0]        training_word;
  logic [23:0]        channel_disable;
  logic [7:0]         status_pin_a_select;
  logic [7:0]         status_pin_b_select;
  logic [7:0]         mode_reg;
  logic [15:0]        row_count;
  somcw_apb_rsp_type  rsp;

  // Sequencer.
  somcw_state_type    state;
  somcw_state_type    next_state;
  logic [6:0]         pix_cnt;
  logic [2:0]         burst_cnt;
  logic [15:0]        row_idx;
  logic               start_pend;

  // Pixel clock pin synchroniser and edge finder.
  logic               mclk_s1;
  logic               mclk_s2;
  logic               mclk_s3;
  logic               ser_load;

  // Serialiser.
  logic [WORD_W-1:0]  lane_sh [NUM_CH:0];
  logic [2:0]         div_cnt;
  logic [3:0]         bit_cnt;
  logic               ser_active;
  logic               oclk;
  logic               pin_a;
  logic               pin_b;
  logic [15:0]        oe_q;
  logic               take_q;

  // The master clock arrives from a pin, so it is synchronised before its edge is looked at.
  wire pix_stb = mclk_s2 & ~mclk_s3;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      ser_load <= 1'b0;
    end
    else
    begin
      mclk_s1 <= i_master_clk;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      ser_load <= pix_stb;        // Lanes load one cycle after the sequencer moves.
    end
  end

  // Mode decode; twelve-bit words squeeze the sensor down to four outputs or fewer.
  wire             twelve_bit = mode_reg[2];
  wire [1:0]       req_mode   = mode_reg[1:0];
  wire [1:0]       eff_mode   = (twelve_bit && (req_mode < MUX_4)) ? MUX_4 : req_mode;
  wire [2:0]       last_burst = 3'((4'h1 << eff_mode) - 4'h1);
  wire [15:0]      rows_last  = (row_count == 16'h0000) ? 16'h0000 : 16'(row_count - 16'h0001);
  wire             burst_end  = (pix_cnt == BURST_LAST);
  wire             row_end    = burst_end && (burst_cnt == last_burst);
  wire             frame_end  = row_end && (row_idx >= rows_last);
  wire [3:0]       word_width = twelve_bit ? WIDTH_12 : WIDTH_10;
  wire [2:0]       bit_div    = twelve_bit ? BIT_DIV_12 : BIT_DIV_10;

  // Next state of the read-out: row overhead, then slot overhead and burst per burst of the row.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:    next_state = start_pend ? ST_ROW_OH : ST_IDLE;
      ST_ROW_OH:  next_state = ST_SLOT_OH;
      ST_SLOT_OH: next_state = ST_BURST;
      ST_BURST:
      begin
        if (frame_end)
          next_state = ST_IDLE;
        else if (row_end)
          next_state = ST_ROW_OH;
        else if (burst_end)
          next_state = ST_SLOT_OH;
        else
          next_state = ST_BURST;
      end
      default:    next_state = ST_IDLE;
    endcase
  end

  // Sequencer advances once per pixel period; a start request waiting in the same cycle wins.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ST_IDLE;
      pix_cnt <= 7'h00;
      burst_cnt <= 3'h0;
      row_idx <= 16'h0000;
      start_pend <= 1'b0;
    end
    else
    begin
      if (i_readout_start)
        start_pend <= 1'b1;
      else if (pix_stb && (state == ST_IDLE))
        start_pend <= 1'b0;
      if (pix_stb)
      begin
        state <= next_state;
        if (state == ST_BURST)
          pix_cnt <= 7'(pix_cnt + 7'h01);
        else
          pix_cnt <= 7'h00;
        if (state == ST_ROW_OH)
          burst_cnt <= 3'h0;
        else if ((state == ST_BURST) && burst_end)
          burst_cnt <= 3'(burst_cnt + 3'h1);
        if (state == ST_IDLE)
          row_idx <= 16'h0000;
        else if ((state == ST_BURST) && row_end)
          row_idx <= 16'(row_idx + 16'h0001);
      end
    end
  end

  // Status flags other than FOT and integration follow the sequencer, so reduced modes stretch them with the longer rows.
  somcw_flags_type flags;
  assign flags.pixel_valid_flag   = (state == ST_BURST);
  assign flags.line_valid_flag    = (state == ST_SLOT_OH) || (state == ST_BURST);
  assign flags.frame_valid_flag   = (state != ST_IDLE);
  assign flags.slot_overhead_flag = (state == ST_SLOT_OH);
  assign flags.row_overhead_flag  = (state == ST_ROW_OH);
  assign flags.fot_flag           = i_fot_active;
  assign flags.integration_block_a_flag = i_inte_a & ~i_fot_active;
  assign flags.integration_block_b_flag = i_inte_b & ~i_fot_active;

  // The control lane never carries the training word, so its idle value is fixed at 512.
  wire [11:0] ctrl_word = CTRL_FIXED | {4'h0, flags};
  wire [11:0] width_mask = twelve_bit ? 12'hfff : 12'h3ff;

  // Each output copies the lowest channel of its group; training word whenever no pixel is valid.
  logic [WORD_W-1:0] lane_word [NUM_CH:0];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_lane_word
      localparam logic [3:0] LANE = 4'(gi);
      wire [3:0] src_ch = LANE & ~4'((5'h01 << eff_mode) - 5'h01);
      assign lane_word[gi] = flags.pixel_valid_flag
                           ? (i_pixel_data[src_ch] & width_mask)
                           : (training_word & width_mask);
    end
  endgenerate
  assign lane_word[NUM_CH] = ctrl_word & width_mask;

  // Bit timing: a bit-rate enable from a divider, toggling the output clock with each bit.
  wire bit_en = ser_active && (div_cnt == 3'(bit_div - 3'h1));

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_cnt <= 3'h0;
      bit_cnt <= 4'h0;
      ser_active <= 1'b0;
      oclk <= 1'b0;
    end
    else if (ser_load)
    begin
      div_cnt <= 3'h0;
      bit_cnt <= 4'h1;
      ser_active <= 1'b1;
      oclk <= 1'b1;
    end
    else if (ser_active)
    begin
      div_cnt <= bit_en ? 3'h0 : 3'(div_cnt + 3'h1);
      if (bit_en)
      begin
        bit_cnt <= 4'(bit_cnt + 4'h1);
        oclk <= ~oclk;
        ser_active <= (bit_cnt != 4'(word_width - 4'h1));  // Last bit stands until the next load.
      end
    end
  end

  // All seventeen lanes load together, so data and control words stay in step.
  generate
    for (gi = 0; gi <= NUM_CH; gi++)
    begin : g_lane_shift
      always_ff @(posedge i_ref_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
          lane_sh[gi] <= 12'h000;
        else if (ser_load)
          lane_sh[gi] <= lane_word[gi];
        else if (bit_en)
          lane_sh[gi] <= {1'b0, lane_sh[gi][WORD_W-1:1]};
      end
      if (gi < NUM_CH)
      begin : g_data_pin
        assign o_data_serial[gi] = lane_sh[gi][0];
      end
    end
  endgenerate
  assign o_ctrl_serial         = lane_sh[NUM_CH][0];
  assign o_serial_output_clock = oclk;

  // Status pins, the pixel handshake and pad enables are registered.
  wire sel_a_bit = (status_pin_a_select <= SEL_FRAMEVAL) && pin_flag(status_pin_a_select, flags);
  wire sel_b_bit = (status_pin_b_select <= SEL_FRAMEVAL) && pin_flag(status_pin_b_select, flags);

  function automatic logic pin_flag(input logic [7:0] sel, input somcw_flags_type f);
    logic r;
    r = 1'b0;
    case (sel)
      SEL_INTE_A:   r = f.integration_block_a_flag;
      SEL_INTE_B:   r = f.integration_block_b_flag;
      SEL_PIXVAL:   r = f.pixel_valid_flag;
      SEL_LINEVAL:  r = f.line_valid_flag;
      SEL_FRAMEVAL: r = f.frame_valid_flag;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction : pin_flag

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      oe_q <= 16'h0000;
      take_q <= 1'b0;
      o_burst_index <= 3'h0;
    end
    else
    begin
      pin_a <= sel_a_bit;
      pin_b <= sel_b_bit;
      oe_q <= ~channel_disable[15:0];
      take_q <= ser_load && flags.pixel_valid_flag;
      o_burst_index <= burst_cnt;
    end
  end
  assign o_status_pin_a = pin_a;
  assign o_status_pin_b = pin_b;
  assign o_data_oe      = oe_q;
  assign o_pixel_take   = take_q;

  // APB decode: one register per aligned word, misaligned or unmapped addresses answer an error.
  wire [9:0] reg_idx  = i_apb.paddr[11:2];
  wire       aligned  = (i_apb.paddr[1:0] == 2'h0);
  wire       setup    = i_apb.psel && !i_apb.penable && !rsp.pready;
  wire       wr_stb   = i_apb.psel && i_apb.penable && rsp.pready && i_apb.pwrite && !rsp.pslverr;
  wire [7:0] wbyte    = i_apb.pwdata[7:0];
  wire [7:0] status_byte = {4'h0, state};
  wire [7:0] rd_byte  =
      (reg_idx == IDX_TRAIN_LO) ? training_word[7:0] :
      (reg_idx == IDX_TRAIN_HI) ? {4'h0, training_word[11:8]} :
      (reg_idx == IDX_CHDIS_0)  ? channel_disable[7:0] :
      (reg_idx == IDX_CHDIS_1)  ? channel_disable[15:8] :
      (reg_idx == IDX_CHDIS_2)  ? channel_disable[23:16] :
      (reg_idx == IDX_SEL_A)    ? status_pin_a_select :
      (reg_idx == IDX_SEL_B)    ? status_pin_b_select :
      (reg_idx == IDX_MODE)     ? {5'h00, mode_reg[2:0]} :
      (reg_idx == IDX_ROWS_LO)  ? row_count[7:0] :
      (reg_idx == IDX_ROWS_HI)  ? row_count[15:8] :
      (reg_idx == IDX_STATUS)   ? status_byte : 8'h00;
  wire       mapped   = aligned && ((reg_idx == IDX_TRAIN_LO) || (reg_idx == IDX_TRAIN_HI) ||
                        (reg_idx == IDX_CHDIS_0) || (reg_idx == IDX_CHDIS_1) ||
                        (reg_idx == IDX_CHDIS_2) || (reg_idx == IDX_SEL_A) ||
                        (reg_idx == IDX_SEL_B) || (reg_idx == IDX_MODE) ||
                        (reg_idx == IDX_ROWS_LO) || (reg_idx == IDX_ROWS_HI) ||
                        (reg_idx == IDX_STATUS));

  // The answer is prepared in the setup cycle, so each access phase lasts exactly one cycle.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rsp <= '0;
    else
    begin
      rsp.pready  <= setup;
      rsp.pslverr <= setup && !mapped;
      rsp.prdata  <= setup ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end
  assign o_apb = rsp;

  // Register writes take effect at the edge that completes the access phase.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      training_word <= TRAIN_RESET;
      channel_disable <= 24'h000000;
      status_pin_a_select <= SEL_RESET;
      status_pin_b_select <= SEL_RESET;
      mode_reg <= MODE_RESET;
      row_count <= ROWS_RESET;
    end
    else if (wr_stb)
    begin
      case (reg_idx)
        IDX_TRAIN_LO: training_word[7:0] <= wbyte;
        IDX_TRAIN_HI: training_word[11:8] <= wbyte[3:0];
        IDX_CHDIS_0:  channel_disable[7:0] <= wbyte;
        IDX_CHDIS_1:  channel_disable[15:8] <= wbyte;
        IDX_CHDIS_2:  channel_disable[23:16] <= wbyte;
        IDX_SEL_A:    status_pin_a_select <= wbyte;
        IDX_SEL_B:    status_pin_b_select <= wbyte;
        IDX_MODE:     mode_reg <= {5'h00, wbyte[2:0]};
        IDX_ROWS_LO:  row_count[7:0] <= wbyte;
        IDX_ROWS_HI:  row_count[15:8] <= wbyte;
        default:      row_count <= row_count;
      endcase
    end
  end

endmodule : somcw_output_stage

// >>> tb/somcw_rx_model.sv
// Purpose: Receiver model that deserialises the control lane and the sixteen data lanes.
// Assumes: 10-bit words, one new bit at every serial clock toggle.
// Notes:   Counting starts at reset, so the first word seen is the idle control word.
`timescale 1ns/10ps
module somcw_rx_model
  import somcw_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_sclk,
  input  wire logic             i_ctrl,
  input  wire logic [15:0]      i_data,
  output      logic             o_word_valid,
  output      logic [9:0]       o_ctrl_word,
  output      logic [15:0][9:0] o_lane_word,
  output      logic             o_sample_ok
);
  logic       sclk_q;
  logic [3:0] bit_cnt;
  wire        bit_edge = i_sclk != sclk_q;
  // Only the three valid flags decide sampling; the other bits are informational.
  assign o_sample_ok = &o_ctrl_word[2:0];
  // LSB first, so each new bit enters at the top; a slipped count would misalign every later word.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_q       <= 1'b0;
      bit_cnt      <= 4'h0;
      o_word_valid <= 1'b0;
      o_ctrl_word  <= 10'h0;
      o_lane_word  <= '0;
    end
    else
    begin
      sclk_q       <= i_sclk;
      o_word_valid <= bit_edge && bit_cnt == 4'h9;
      if (bit_edge)
      begin
        bit_cnt     <= (bit_cnt == 4'h9) ? 4'h0 : bit_cnt + 4'h1;
        o_ctrl_word <= {i_ctrl, o_ctrl_word[9:1]};
        for (int j = 0; j < 16; j++)
          o_lane_word[j] <= {i_data[j], o_lane_word[j][9:1]};
      end
    end
  end
endmodule : somcw_rx_model

// >>> tb/somcw_chk_properties.sv
// Purpose: Port-level checks of the register bus and the serial word stream.
// Assumes: 10-bit words, so one word is ten serial clock toggles.
// Notes:   Twelve-bit words would need a count of twelve and are not covered here.
`timescale 1ns/10ps
module somcw_chk
  import somcw_pkg::*;
(
  input wire logic                         i_ref_clk,
  input wire logic                         i_arst_n,
  input wire somcw_pkg::somcw_apb_req_type i_apb,
  input wire somcw_pkg::somcw_apb_rsp_type o_apb,
  input wire logic [15:0]                  o_data_serial,
  input wire logic [15:0]                  o_data_oe,
  input wire logic                         o_ctrl_serial,
  input wire logic                         o_serial_output_clock
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic       sclk_q;
  logic [3:0] cnt;
  logic       done_q;
  logic       vflag;
  logic [9:0] sh;
  logic [9:0] prev_cw;
  logic [7:0] run;
  wire        tog  = o_serial_output_clock != sclk_q;
  wire        load = tog && cnt == 4'h0;
  wire        idle = !(load ? o_ctrl_serial : vflag);
  // Rebuild each control word so later checks can look at whole words and their neighbours.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sclk_q  <= 1'b0;
      cnt     <= 4'h0;
      done_q  <= 1'b0;
      vflag   <= 1'b0;
      sh      <= 10'h0;
      prev_cw <= 10'h200;
      run     <= 8'h0;
    end
    else
    begin
      sclk_q <= o_serial_output_clock;
      done_q <= tog && cnt == 4'h9;
      vflag  <= load ? o_ctrl_serial : vflag;
      if (tog)
      begin
        sh  <= {o_ctrl_serial, sh[9:1]};
        cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
      end
      if (done_q)
      begin
        prev_cw <= sh;
        run     <= sh[0] ? run + 8'h1 : 8'h0;
      end
    end
  end
  sequence hold_s;
    $stable(o_serial_output_clock) [*2];
  endsequence
  apb_ready_a: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready) else $error("no ready");
  apb_pulse_a: assert property (o_apb.pready |=> !o_apb.pready) else $error("ready too long");
  load_clock_a: assert property (load |-> o_serial_output_clock) else $error("bit0 not high");
  bit_hold_a: assert property (tog |=> hold_s) else $error("bit too short");
  lane_sync_a: assert property ($changed(o_data_serial) || $changed(o_ctrl_serial) |-> tog)
    else $error("lane off clock");
  fixed_bits_a: assert property (done_q |-> sh[9:8] == 2'b10) else $error("fixed bits");
  valid_nest_a: assert property (done_q && sh[0] |-> sh[4:1] == 4'h3) else $error("flag nesting");
  slot_next_a: assert property (done_q && prev_cw[3] |-> sh[0]) else $error("slot length");
  inte_mask_a: assert property (done_q && sh[5] |-> sh[7:6] == 2'b00) else $error("inte in fot");
  burst_len_a: assert property (done_q && !sh[0] && prev_cw[0] |-> run == 8'h80) else $error("burst");
  train_all_a: assert property (tog && &o_data_oe && idle |-> o_data_serial inside {16'h0, 16'hffff})
    else $error("lanes differ");
endmodule : somcw_chk
bind somcw_output_stage somcw_chk u_chk (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_apb(i_apb),
  .o_apb(o_apb), .o_data_serial(o_data_serial), .o_data_oe(o_data_oe), .o_ctrl_serial(o_ctrl_serial),
  .o_serial_output_clock(o_serial_output_clock));

// >>> tb/tb.sv
// Purpose: Self-checking bench for the sensor output stage.
// Assumes: 10-bit words; the bench makes the pixel clock and holds pixels fixed for a frame.
// Notes:   Words are queued at each pixel edge and matched as the receiver delivers them.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import somcw_pkg::*;
;
  typedef struct {logic [9:0] ctrl; logic [15:0][9:0] lane; logic [15:0] en;} somcw_exp_type;
  logic              clk, arst_n, mclk, start, fot, ia, ib, take, cser, sclk, pin_a, pin_b, rx_v, rx_ok, pend;
  somcw_apb_req_type apb_req;
  somcw_apb_rsp_type apb_rsp;
  somcw_pix_type     pix;
  logic [15:0]       dser, oe, en;
  logic [2:0]        bidx;
  logic [9:0]        rx_c;
  logic [15:0][9:0]  rx_l;
  logic [11:0]       train;
  logic [7:0]        cur_f;
  somcw_exp_type     expq[$];
  somcw_exp_type     ex, ox;
  int                err_total, cmp_count, st, pos, bst, row, nb, rows, mode, takes, sel_a, sel_b;
  int                flag_bit[5] = '{6, 7, 0, 1, 2};
  somcw_output_stage uut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_master_clk(mclk), .i_readout_start(start), .i_fot_active(fot), .i_inte_a(ia), .i_inte_b(ib),
    .i_pixel_data(pix), .o_pixel_take(take), .o_burst_index(bidx), .o_data_serial(dser), .o_data_oe(oe),
    .o_ctrl_serial(cser), .o_serial_output_clock(sclk), .o_status_pin_a(pin_a), .o_status_pin_b(pin_b));
  somcw_rx_model rx (.i_clk(clk), .i_rst_n(arst_n), .i_sclk(sclk), .i_ctrl(cser), .i_data(dser),
    .o_word_valid(rx_v), .o_ctrl_word(rx_c), .o_lane_word(rx_l), .o_sample_ok(rx_ok));
  // Free-running reference clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // One register transfer; the request stands until ready is seen at an edge.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, idx, d, rd, er);
  endtask : wr
  task automatic rdchk(input logic [9:0] idx, input logic [7:0] d, input logic e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, idx, 8'h0, rd, er);
    `CHK(rd, {24'h0, d})
    `CHK(er, e)
  endtask : rdchk
  // Step the sequencer model at a pixel edge and note the word it must produce.
  task automatic rise();
    case (st)
      0: if (pend) begin st = 1; pend = 1'b0; row = 0; end
      1: begin st = 2; bst = 0; end
      2: begin st = 3; pos = 0; end
      default:
        if (pos < 127) pos++;
        else if (bst + 1 < nb) begin bst++; st = 2; end
        else if (row + 1 < rows) begin row++; st = 1; end
        else st = 0;
    endcase
    cur_f = {ib & !fot, ia & !fot, fot, st == 1, st == 2, st != 0, st >= 2, st == 3};
    ex.ctrl = {2'b10, cur_f};
    ex.en = en;
    for (int j = 0; j < 16; j++)
      ex.lane[j] = (st == 3) ? pix[j & ~((1 << mode) - 1)][9:0] : train[9:0];
    expq.push_back(ex);
  endtask : rise
  // Pixel clock of 160 ns; status inputs change mid-period, well away from the pixel edge.
  task automatic pixels(input int n);
    repeat (n)
    begin
      mclk <= 1'b1;
      rise();
      repeat (20) @(posedge clk);
      mclk <= 1'b0;
      `CHK(pin_a, cur_f[flag_bit[sel_a]])
      `CHK(pin_b, cur_f[flag_bit[sel_b]])
      if (st >= 2)
        `CHK(bidx, 3'(bst))
      fot <= ($urandom % 4) == 0;
      ia <= 1'($urandom);
      ib <= 1'($urandom);
      repeat (20) @(posedge clk);
    end
  endtask : pixels
  // Match each delivered word against the oldest note.
  always @(posedge clk)
    if (rx_v === 1'b1)
    begin
      ox = expq.pop_front();
      `CHK(rx_c, ox.ctrl)
      `CHK(rx_ok, ox.ctrl[0])
      for (int j = 0; j < 16; j++)
        if (ox.en[j])
          `CHK(rx_l[j], ox.lane[j])
    end
  always @(posedge clk)
    if (take === 1'b1)
      takes++;
  initial
  begin
    #370000;
    err_total++;
    complete_run();
  end
  initial
  begin
    {arst_n, mclk, start, fot, ia, ib, pend} = '0;
    {st, sel_a, sel_b, mode, nb, rows} = '0;
    apb_req = '0;
    pix = '0;
    train = 12'h3a5;
    en = 16'hffff;
    void'($urandom(21807));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(IDX_TRAIN_LO, 8'ha5, 1'b0);
    rdchk(IDX_TRAIN_HI, 8'h03, 1'b0);
    rdchk(IDX_ROWS_LO, 8'h40, 1'b0);
    rdchk(IDX_ROWS_HI, 8'h04, 1'b0);
    rdchk(IDX_SEL_B, 8'h00, 1'b0);
    rdchk(10'h3ff, 8'h00, 1'b1);
    pixels(3);
    `CHK(oe, 16'hffff)
    $display("reset and idle test done");
    wr(IDX_ROWS_HI, 8'h00);
    for (int f = 0; f < 4; f++)
    begin
      mode = (f == 0) ? 0 : 4 - f;
      rows = (f == 0) ? 2 : 1;
      nb = 1 << mode;
      train = 12'($urandom);
      sel_a = f;
      sel_b = 4 - f;
      wr(IDX_TRAIN_LO, train[7:0]);
      wr(IDX_TRAIN_HI, {4'h0, train[11:8]});
      wr(IDX_MODE, 8'(mode));
      wr(IDX_ROWS_LO, 8'(rows));
      wr(IDX_SEL_A, 8'(sel_a));
      wr(IDX_SEL_B, 8'(sel_b));
      for (int c = 0; c < 16; c++)
        pix[c] <= 12'($urandom);
      takes = 0;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      pend = 1'b1;
      pixels(rows * (1 + nb * 129) + 2);
      `CHK(takes, rows * nb * 128)
      $display("frame test %0d in mode %0d done", f, mode);
    end
    wr(IDX_CHDIS_0, 8'haa);
    wr(IDX_CHDIS_1, 8'haa);
    en = 16'h5555;
    pixels(2);
    `CHK(oe, 16'h5555)
    repeat (60) @(posedge clk);
    `CHK(expq.size(), 0)
    $display("lane disable test done");
    complete_run();
  end
endmodule : tb
